/* File: hw/pmt_pkg.sv */
// package for the period match timer: offsets, fields, resets, types
package pmt_pkg;
    localparam logic [2:0] ADDR_COUNT = 3'h0;
    localparam logic [2:0] ADDR_PERIOD = 3'h1;
    localparam logic [2:0] ADDR_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_MASK = 3'h4;
    localparam logic [2:0] ADDR_TSEL = 3'h5;
    localparam int CTL_PRE_LSB = 0;
    localparam int CTL_ON_BIT = 2;
    localparam int CTL_POST_LSB = 3;
    localparam int STAT_MATCH_BIT = 0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_MASK = 8'h7F;
    localparam logic [3:0] POST_RESET = 4'h0;
    localparam logic [3:0] PRE_RESET = 4'h0;
    localparam logic [2:0] TSEL_RESET = 3'h0;
    localparam logic [2:0] OWN_TIMER_ID = 3'h3;
    localparam logic [3:0] PRE_TERM_1 = 4'h0;
    localparam logic [3:0] PRE_TERM_4 = 4'h3;
    localparam logic [3:0] PRE_TERM_16 = 4'hF;
    localparam int CPU_DIV = 4;
    localparam logic [1:0] CPU_DIV_TERM = 2'(CPU_DIV - 1);

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pmt_bus_type;

    typedef struct packed {
        logic [3:0] post;
        logic on;
        logic [1:0] pre;
    } pmt_ctl_type;
endpackage

/* File: hw/pmt_scaler.sv */
// prescaler with clearable count and selectable ratio
`timescale 1ns/1ps
`default_nettype none
module pmt_scaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [1:0] sel,
    output logic pulse
);
    logic [3:0] cnt;
    wire logic [3:0] term;
    wire logic at_term;

    assign term = (sel == 2'h0) ? pmt_pkg::PRE_TERM_1 :
                  (sel == 2'h1) ? pmt_pkg::PRE_TERM_4 :
                  pmt_pkg::PRE_TERM_16;
    assign at_term = (cnt >= term);
    assign pulse = tick && at_term && !clear;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            cnt <= pmt_pkg::PRE_RESET;
        end else if (tick) begin
            cnt <= at_term ? pmt_pkg::PRE_RESET : cnt + 4'h1;
        end
    end
endmodule // pmt_scaler
`default_nettype wire

/* File: hw/pmt_timer.sv */
// 8-bit period match timer with prescaler, postscaler and interrupt
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    output logic pwm_base
);
    pmt_pkg::pmt_bus_type bus;
    logic [7:0] count_register;
    logic [7:0] period_register;
    logic [7:0] timer_control_register;
    logic match_flag;
    logic match_interrupt_enable;
    logic [2:0] timer_select;
    logic [1:0] cpu_div;
    logic [3:0] post_cnt;
    logic next_match_flag;
    logic [7:0] next_rdata;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    wire pmt_pkg::pmt_ctl_type ctl = pmt_pkg::pmt_ctl_type'(
        timer_control_register[6:0]);
    wire logic wr_count = bus.wr && (bus.addr == pmt_pkg::ADDR_COUNT);
    wire logic wr_period = bus.wr && (bus.addr == pmt_pkg::ADDR_PERIOD);
    wire logic wr_ctl = bus.wr && (bus.addr == pmt_pkg::ADDR_CONTROL);
    wire logic wr_stat = bus.wr && (bus.addr == pmt_pkg::ADDR_STATUS);
    wire logic wr_mask = bus.wr && (bus.addr == pmt_pkg::ADDR_MASK);
    wire logic wr_tsel = bus.wr && (bus.addr == pmt_pkg::ADDR_TSEL);
    // scaler clear on count or control write
    wire logic scaler_clear = wr_count || wr_ctl;
    wire logic insn_tick = (cpu_div == pmt_pkg::CPU_DIV_TERM) && ctl.on;
    wire logic count_step;
    wire logic at_period = (count_register == period_register);
    wire logic match = count_step && at_period;
    wire logic post_done = match && (post_cnt >= ctl.post);
    // only the select code of this timer passes the time base on
    wire logic own_select =
        (timer_select == pmt_pkg::OWN_TIMER_ID);
    // irq follows the new enable in the write cycle itself
    wire logic next_enable = wr_mask ? bus.wdata[pmt_pkg::STAT_MATCH_BIT]
                                     : match_interrupt_enable;

    pmt_scaler u_pre (
        .clk(clk),
        .rst(rst),
        .clear(scaler_clear),
        .tick(insn_tick),
        .sel(ctl.pre),
        .pulse(count_step)
    );

    // instruction clock: free divider; gated by the on bit
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_div <= 2'h0;
        end else begin
            cpu_div <= cpu_div + 2'h1;
        end
    end

    // count: write wins over increment; control write leaves it alone
    always_ff @(posedge clk) begin
        if (rst) begin
            count_register <= pmt_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_register <= bus.wdata;
        end else if (count_step) begin
            count_register <= at_period ? pmt_pkg::COUNT_RESET
                                        : count_register + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            post_cnt <= pmt_pkg::POST_RESET;
        end else if (scaler_clear) begin
            post_cnt <= pmt_pkg::POST_RESET;
        end else if (match) begin
            post_cnt <= post_done ? pmt_pkg::POST_RESET
                                  : post_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            period_register <= pmt_pkg::PERIOD_RESET;
            timer_control_register <= pmt_pkg::CONTROL_RESET;
            match_interrupt_enable <= 1'b0;
            timer_select <= pmt_pkg::TSEL_RESET;
        end else begin
            if (wr_period) begin
                period_register <= bus.wdata;
            end
            if (wr_ctl) begin
                timer_control_register <= bus.wdata & pmt_pkg::CONTROL_MASK;
            end
            if (wr_mask) begin
                match_interrupt_enable <= bus.wdata[pmt_pkg::STAT_MATCH_BIT];
            end
            if (wr_tsel) begin
                timer_select <= bus.wdata[2:0];
            end
        end
    end

    // set beats a write-one-to-clear in the same cycle
    always_comb begin
        next_match_flag = match_flag;
        if (wr_stat && bus.wdata[pmt_pkg::STAT_MATCH_BIT]) begin
            next_match_flag = 1'b0;
        end
        if (post_done) begin
            next_match_flag = 1'b1;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (bus.addr)
            pmt_pkg::ADDR_COUNT: next_rdata = count_register;
            pmt_pkg::ADDR_PERIOD: next_rdata = period_register;
            pmt_pkg::ADDR_CONTROL: next_rdata = timer_control_register;
            pmt_pkg::ADDR_STATUS: next_rdata = {7'h00, match_flag};
            pmt_pkg::ADDR_MASK: next_rdata = {7'h00, match_interrupt_enable};
            pmt_pkg::ADDR_TSEL: next_rdata = {5'h00, timer_select};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            match_flag <= 1'b0;
            rdata <= 8'h00;
            irq <= 1'b0;
            pwm_base <= 1'b0;
        end else begin
            match_flag <= next_match_flag;
            rdata <= bus.rd ? next_rdata : 8'h00;
            irq <= next_match_flag && next_enable;
            // unselected pwm units see nothing from this timer
            pwm_base <= match && own_select;
        end
    end

    // a read of the flag: reads of status have no side effect
    property p_count_reset;
        @(posedge clk) rst |=> (count_register == 8'h00);
    endproperty
    a_count_reset: assert property (p_count_reset)
        else $error("count not cleared by reset");

    property p_period_reset;
        @(posedge clk) rst |=> (period_register == 8'hFF);
    endproperty
    a_period_reset: assert property (p_period_reset)
        else $error("period not all ones after reset");

    property p_stopped;
        @(posedge clk) disable iff (rst)
        (!ctl.on && !wr_count) |=> $stable(count_register);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("count moved while timer off");

    property p_wrap;
        @(posedge clk) disable iff (rst)
        (count_step && at_period && !wr_count) |=> (count_register == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap at period");

    property p_ctl_keeps_count;
        @(posedge clk) disable iff (rst)
        (wr_ctl && !count_step) |=> $stable(count_register);
    endproperty
    a_ctl_keeps_count: assert property (p_ctl_keeps_count)
        else $error("control write changed count");

    property p_post_clear;
        @(posedge clk) disable iff (rst)
        scaler_clear |=> (post_cnt == 4'h0);
    endproperty
    a_post_clear: assert property (p_post_clear)
        else $error("postscaler not cleared by write");

    property p_flag_set;
        @(posedge clk) disable iff (rst)
        post_done |=> match_flag;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match flag not set");

    property p_irq;
        @(posedge clk) disable iff (rst)
        (match_flag && match_interrupt_enable) |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq low with enabled flag set");

    // cycles since the last count step; the first step after a clear
    // lands at a free divider phase, so only later steps are timed
    logic [6:0] step_gap;
    logic step_seen;

    always_ff @(posedge clk) begin
        if (rst || scaler_clear) begin
            step_gap <= 7'h00;
            step_seen <= 1'b0;
        end else if (count_step) begin
            step_gap <= 7'h00;
            step_seen <= 1'b1;
        end else if (step_gap != 7'h7F) begin
            step_gap <= step_gap + 7'h01;
        end
    end

    property p_prescale16;
        @(posedge clk) disable iff (rst)
        (count_step && step_seen && ctl.pre[1])
            |-> (step_gap == {1'b0, pmt_pkg::PRE_TERM_16, 2'b11});
    endproperty
    a_prescale16: assert property (p_prescale16)
        else $error("prescale 16 step spacing wrong");

    property p_prescale_low;
        @(posedge clk) disable iff (rst)
        (count_step && step_seen && !ctl.pre[1])
            |-> (step_gap == (ctl.pre[0]
                ? {1'b0, pmt_pkg::PRE_TERM_4, 2'b11}
                : {1'b0, pmt_pkg::PRE_TERM_1, 2'b11}));
    endproperty
    a_prescale_low: assert property (p_prescale_low)
        else $error("prescale 1 or 4 step spacing wrong");

    property p_irq_low;
        @(posedge clk) disable iff (rst)
        !(match_flag && match_interrupt_enable) |-> !irq;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("irq high with no enabled flag");

    property p_flag_hold;
        @(posedge clk) disable iff (rst)
        (match_flag && !(wr_stat && wdata[pmt_pkg::STAT_MATCH_BIT]))
            |=> match_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("match flag dropped without a clear");

    property p_flag_clear;
        @(posedge clk) disable iff (rst)
        (wr_stat && wdata[pmt_pkg::STAT_MATCH_BIT] && !post_done)
            |=> !match_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("match flag not cleared by write");

    property p_post_clear_ctl;
        @(posedge clk) disable iff (rst)
        wr_ctl |=> (post_cnt == pmt_pkg::POST_RESET);
    endproperty
    a_post_clear_ctl: assert property (p_post_clear_ctl)
        else $error("control write left postscaler running");

    property p_post_reset;
        @(posedge clk) rst |=> (post_cnt == pmt_pkg::POST_RESET);
    endproperty
    a_post_reset: assert property (p_post_reset)
        else $error("postscaler not cleared by reset");

    property p_post_step;
        @(posedge clk) disable iff (rst)
        (match && !post_done) |=> (post_cnt == $past(post_cnt) + 4'h1);
    endproperty
    a_post_step: assert property (p_post_step)
        else $error("postscaler did not count a match");

    property p_count_write;
        @(posedge clk) disable iff (rst)
        wr_count |=> (count_register == $past(wdata));
    endproperty
    a_count_write: assert property (p_count_write)
        else $error("count write not taken");

    property p_period_write;
        @(posedge clk) disable iff (rst)
        wr_period |=> (period_register == $past(wdata));
    endproperty
    a_period_write: assert property (p_period_write)
        else $error("period write not taken");

    property p_read_count;
        @(posedge clk) disable iff (rst)
        (rd && (addr == pmt_pkg::ADDR_COUNT))
            |=> (rdata == $past(count_register));
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("count read returned a wrong value");

    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        !rd |=> (rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");

    property p_step_one;
        @(posedge clk) disable iff (rst)
        (count_step && !at_period && !wr_count)
            |=> (count_register == $past(count_register) + 8'h01);
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("count did not advance by one");

    property p_off_no_step;
        @(posedge clk) disable iff (rst)
        !ctl.on |-> !count_step;
    endproperty
    a_off_no_step: assert property (p_off_no_step)
        else $error("prescaler stepped while timer off");

    property p_pwm_base;
        @(posedge clk) disable iff (rst)
        (match && own_select) |=> pwm_base;
    endproperty
    a_pwm_base: assert property (p_pwm_base)
        else $error("time base pulse missing at a match");

    property p_pwm_gate;
        @(posedge clk) disable iff (rst)
        !own_select |=> !pwm_base;
    endproperty
    a_pwm_gate: assert property (p_pwm_gate)
        else $error("time base reached an unselected unit");
endmodule // pmt_timer
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the period match timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq;
    logic pwm_base;
    int error_cnt = 0;
    int n_compared = 0;
    logic [7:0] v;
    int k;
    int n;
    logic [3:0] posts [3] = '{4'h0, 4'h2, 4'hF};
    logic [7:0] rst_exp [8] = '{8'h00, 8'hFF, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00, 8'h00};
    // rows: address, write value, value read back
    logic [18:0] rows [7] = '{{3'h1, 8'h5A, 8'h5A}, {3'h2, 8'h80, 8'h00},
        {3'h0, 8'h12, 8'h12}, {3'h4, 8'h01, 8'h01}, {3'h5, 8'hFF, 8'h07},
        {3'h6, 8'hAA, 8'h00}, {3'h7, 8'h55, 8'h00}};

    pmt_timer dut (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .irq(irq),
        .pwm_base(pwm_base)
    );

    always #2.5 clk = ~clk;

    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one idle edge between strobes keeps each strobe a single pulse
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [2:0] a,
                          input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask

    task automatic irq_chk(input string nm, input logic e);
        repeat (2) @(posedge clk);
        #1;
        chk(nm, {7'h00, e}, {7'h00, irq});
    endtask

    task automatic reset_check();
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset value", 3'(i), rst_exp[i]);
        end
        chk("irq after reset", 8'h00, {7'h00, irq});
    endtask

    // cycles between two pulses, free of the divider phase
    task automatic pwm_gap(output int g);
        #1;
        k = 0;
        while (pwm_base !== 1'b1 && k < 2000) begin
            @(posedge clk);
            #1;
            k++;
        end
        g = 0;
        do begin
            @(posedge clk);
            #1;
            g++;
        end while (pwm_base !== 1'b1 && g < 2000);
    endtask

    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        for (int i = 0; i < 7; i++) begin
            bus_wr(rows[i][18:16], rows[i][15:8]);
            rd_chk("row readback", rows[i][18:16], rows[i][7:0]);
        end
        // timer off: count holds through a control write
        bus_wr(pmt_pkg::ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge clk);
        rd_chk("count held", pmt_pkg::ADDR_COUNT, 8'h12);
        bus_wr(pmt_pkg::ADDR_COUNT, 8'h00);
        bus_wr(pmt_pkg::ADDR_PERIOD, 8'h02);
        bus_wr(pmt_pkg::ADDR_TSEL, {5'h00, pmt_pkg::OWN_TIMER_ID});
        for (int c = 0; c < 4; c++) begin
            bus_wr(pmt_pkg::ADDR_CONTROL, 8'h04 | 8'(c));
            pwm_gap(n);
            chk("pwm gap", 8'(12 * (c == 0 ? 1 : c == 1 ? 4 : 16)), 8'(n));
        end
        bus_wr(pmt_pkg::ADDR_CONTROL, 8'h04);
        bus_wr(pmt_pkg::ADDR_TSEL, 8'h02);
        n = 0;
        repeat (200) begin
            @(posedge clk);
            #1;
            if (pwm_base === 1'b1) n++;
        end
        chk("pwm unselected", 8'h00, 8'(n));
        bus_wr(pmt_pkg::ADDR_TSEL, 8'h03);
        bus_wr(pmt_pkg::ADDR_PERIOD, 8'h01);
        bus_wr(pmt_pkg::ADDR_MASK, 8'h01);
        foreach (posts[j]) begin
            bus_wr(pmt_pkg::ADDR_CONTROL, 8'h00);
            bus_wr(pmt_pkg::ADDR_STATUS, 8'h01);
            bus_wr(pmt_pkg::ADDR_COUNT, 8'h00);
            bus_wr(pmt_pkg::ADDR_CONTROL, {1'b0, posts[j], 3'b100});
            n = 0;
            k = 0;
            while (irq !== 1'b1 && k < 1000) begin
                @(posedge clk);
                #1;
                k++;
                if (pwm_base === 1'b1) n++;
            end
            chk("matches per flag", 8'(posts[j]) + 8'h01, 8'(n));
        end
        // stopped, so no new match can refill the flag
        bus_wr(pmt_pkg::ADDR_CONTROL, 8'h00);
        rd_chk("flag set", pmt_pkg::ADDR_STATUS, 8'h01);
        bus_wr(pmt_pkg::ADDR_MASK, 8'h00);
        irq_chk("irq masked", 1'b0);
        rd_chk("flag kept", pmt_pkg::ADDR_STATUS, 8'h01);
        bus_wr(pmt_pkg::ADDR_MASK, 8'h01);
        irq_chk("irq unmasked", 1'b1);
        bus_wr(pmt_pkg::ADDR_STATUS, 8'h01);
        irq_chk("irq cleared", 1'b0);
        rd_chk("flag cleared", pmt_pkg::ADDR_STATUS, 8'h00);
        // 1:16 prescale: a count write restarts the 64 cycle step
        bus_wr(pmt_pkg::ADDR_PERIOD, 8'hFF);
        bus_wr(pmt_pkg::ADDR_CONTROL, 8'h06);
        repeat (100) @(posedge clk);
        bus_wr(pmt_pkg::ADDR_COUNT, 8'h20);
        repeat (50) @(posedge clk);
        rd_chk("count after write", pmt_pkg::ADDR_COUNT, 8'h20);
        repeat (20) @(posedge clk);
        rd_chk("first step", pmt_pkg::ADDR_COUNT, 8'h21);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reset_check();
        complete_run();
    end
endmodule // tb
`default_nettype wire
